/* File: tw_defs.svh */
/*
  Constants of the two-wire serial unit: register offsets, control bit positions,
  status codes, reset values and bus timing.
  Assumes inclusion by bare name from any file that needs them; definitions only.
*/
`ifndef TW_DEFS_SVH
`define TW_DEFS_SVH

// ==========================================================================
// Register byte offsets on the APB word map
`define TW_OFF_CTRL 8'h00
`define TW_OFF_STAT 8'h04
`define TW_OFF_DATA 8'h08
`define TW_OFF_ADDR 8'h0c

// ==========================================================================
// Control register bit positions
`define TW_B_FLAG 7
`define TW_B_ACK 6
`define TW_B_STA 5
`define TW_B_STO 4
`define TW_B_WCOL 3
`define TW_B_EN 2
`define TW_B_IE 0

// ==========================================================================
// Reset values
`define TW_RST_BYTE 8'h00
`define TW_RST_CODE 8'hf8

// ==========================================================================
// Status codes, prescaler bits zero
`define TW_CODE_START 8'h08
`define TW_CODE_RSTART 8'h10
`define TW_CODE_AW_ACK 8'h18
`define TW_CODE_AW_NACK 8'h20
`define TW_CODE_DTX_ACK 8'h28
`define TW_CODE_DTX_NACK 8'h30
`define TW_CODE_ARB_LOST 8'h38
`define TW_CODE_AR_ACK 8'h40
`define TW_CODE_AR_NACK 8'h48
`define TW_CODE_DRX_ACK 8'h50
`define TW_CODE_DRX_NACK 8'h58
`define TW_CODE_OWN_W 8'h60
`define TW_CODE_OWN_W_LOST 8'h68
`define TW_CODE_GC_W 8'h70
`define TW_CODE_GC_W_LOST 8'h78
`define TW_CODE_OWN_D_ACK 8'h80
`define TW_CODE_OWN_D_NACK 8'h88
`define TW_CODE_GC_D_ACK 8'h90
`define TW_CODE_GC_D_NACK 8'h98
`define TW_CODE_OWN_R 8'ha8

// ==========================================================================
// Timing and general call address
`define TW_CLK_PERIOD_NS 8
`define TW_SCL_HALF_NS 5000
`define TW_GC_ADDR 7'h00

`endif

/* File: tw_pkg.sv */
/*
  Types of the two-wire serial unit.
  Assumes nothing; used by scoped name only.
*/
package tw_pkg;

  // ==========================================================================
  // Sequencer states
  typedef enum logic [2:0] {
    s_idle = 3'b000,
    s_mstart = 3'b001,
    s_mrestart = 3'b010,
    s_mbyte = 3'b011,
    s_mstop = 3'b100,
    s_wait = 3'b101,
    s_sbits = 3'b110,
    s_sack = 3'b111
  } tw_state_t;

endpackage

/* File: tw_sync.sv */
/*
  Two-flop synchroniser for a group of pin inputs.
  Assumes inputs are asynchronous to clk; only the second stage leaves the module.
*/
`timescale 1ns/1ps
`default_nettype none

module tw_sync #(
  parameter int W = 2
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta_ff;

  // ==========================================================================
  // Idle bus level is high, so both stages reset high
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_ff <= '1;
      q <= '1;
    end else begin
      meta_ff <= d;
      q <= meta_ff;
    end
  end

endmodule // tw_sync

`default_nettype wire

/* File: tw_core.sv */
/*
  Two-wire serial unit: master receiver/transmitter sequencing, slave receiver
  entry, address match with sleep wake-up, and an APB register slave.
  Assumes open-drain pads outside resolve scl/sda from the enables, and a power
  manager that raises deep_sleep for every sleep mode except idle.
*/
// The implementer's own choices: the APB slave port and the address map.
// Summary of operation
// - A start request waits for a free bus, then drives START.
// - After START the flag sets with status 0x08.
// - Address direction bit selects master transmit or master receive.
// - Writing one to the flag clears it and lets the sequence continue.
// - After the read address and its acknowledge: status 0x38, 0x40 or 0x48.
// - In 0x40/0x50 a clear receives a byte, ACK per ack_enable.
// - In 0x48/0x58 start/stop bits pick restart, stop, or stop then start.
// - Status 0x38: release bus, or queue START until the bus frees.
// - After repeated START, a read address stays receive, write switches.
// - Received byte sits in the data register when the flag sets.
// - Repeated START keeps bus ownership without a STOP.
// - Own address from bits 7:1; bit 0 enables general call 0x00.
// - Own or general call address with write enters slave receive, flag sets.
// - Losing arbitration then being addressed reports 0x68 or 0x78.
// - ack_enable cleared mid-transfer gives NOT ACK after next data byte.
// - ack_enable low ignores own address but keeps watching the bus.
// - In deep sleep with ack_enable set, address match still works and wakes.
// - After a wake-up match SCL stays low until the flag is cleared.
// - Data register is not updated while asleep.
`timescale 1ns/1ps
`default_nettype none
`include "tw_defs.svh"

module tw_core #(
  parameter int AW = 8,
  parameter int HALF_CYC = (`TW_SCL_HALF_NS + `TW_CLK_PERIOD_NS - 1) / `TW_CLK_PERIOD_NS
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  input wire logic deep_sleep,
  output logic wake_req
);

  localparam logic [15:0] HALF_M1 = 16'(HALF_CYC - 1);
  localparam logic [15:0] QTR = 16'(HALF_CYC / 2);

  tw_pkg::tw_state_t state_ff;
  logic scl_s, sda_s, scl_q, sda_q;
  logic scl_rise, scl_fall, start_det, stop_det, busy_ff;
  logic [15:0] cnt_ff;
  logic [1:0] phase_ff;
  logic [3:0] bit_ff;
  logic [7:0] sh_ff, status_ff, data_ff, own_ff;
  logic tx_ff, addr_ph_ff, lost_ff, gc_ff, dir_ff, ack_out_ff, rs_ff;
  logic set_ff, stop_done_ff, load_ff;
  logic flag_ff, ack_en_ff, sta_ff, sto_ff, wcol_ff, en_ff, ie_ff;
  logic half_done, qtr_pt, addr_hit, gc_hit, bit_drv, ackd;
  logic apb_acc, wr_go, rd_go, reg_hit;
  logic [7:0] rd_byte;

  // ==========================================================================
  // Pin sampling and bus condition detection
  tw_sync #(.W(2)) u_sync (
    .clk(pclk),
    .rst_n(presetn),
    .d({scl_i, sda_i}),
    .q({scl_s, sda_s})
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl_s;
      sda_q <= sda_s;
    end
  end

  assign scl_rise = scl_s & ~scl_q;
  assign scl_fall = ~scl_s & scl_q;
  assign start_det = scl_s & scl_q & sda_q & ~sda_s;
  assign stop_det = scl_s & scl_q & ~sda_q & sda_s;

  // Bus is free between a STOP and the next START
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy_ff <= 1'b0;
    end else if (start_det) begin
      busy_ff <= 1'b1;
    end else if (stop_det || !en_ff) begin
      busy_ff <= 1'b0;
    end
  end

  // ==========================================================================
  // Combinational helpers
  assign half_done = (cnt_ff == HALF_M1);
  assign qtr_pt = (cnt_ff == QTR);
  assign gc_hit = own_ff[0] && (sh_ff[7:1] == `TW_GC_ADDR);
  // ack_enable gates recognition; the bus is still followed while it is low
  assign addr_hit = ack_en_ff && ((sh_ff[7:1] == own_ff[7:1]) || gc_hit);
  assign bit_drv = (bit_ff < 4'd8) ? (tx_ff & ~sh_ff[7]) : (~tx_ff & ack_out_ff);
  assign ackd = ~sda_s;

  // ==========================================================================
  // Bus sequencer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff <= tw_pkg::s_idle;
      cnt_ff <= 16'h0000;
      phase_ff <= 2'h0;
      bit_ff <= 4'h0;
      sh_ff <= `TW_RST_BYTE;
      status_ff <= `TW_RST_CODE;
      tx_ff <= 1'b0;
      addr_ph_ff <= 1'b0;
      lost_ff <= 1'b0;
      gc_ff <= 1'b0;
      dir_ff <= 1'b0;
      ack_out_ff <= 1'b0;
      rs_ff <= 1'b0;
      set_ff <= 1'b0;
      stop_done_ff <= 1'b0;
      load_ff <= 1'b0;
      scl_oe <= 1'b0;
      sda_oe <= 1'b0;
    end else if (!en_ff) begin
      state_ff <= tw_pkg::s_idle;
      scl_oe <= 1'b0;
      sda_oe <= 1'b0;
      set_ff <= 1'b0;
      stop_done_ff <= 1'b0;
      load_ff <= 1'b0;
    end else begin
      set_ff <= 1'b0;
      stop_done_ff <= 1'b0;
      load_ff <= 1'b0;
      case (state_ff)
        tw_pkg::s_idle: begin
          scl_oe <= 1'b0;
          sda_oe <= 1'b0;
          cnt_ff <= 16'h0000;
          phase_ff <= 2'h0;
          if (start_det) begin
            state_ff <= tw_pkg::s_sbits;
            bit_ff <= 4'h0;
            addr_ph_ff <= 1'b1;
            lost_ff <= 1'b0;
          end else if (sta_ff && !busy_ff && !deep_sleep) begin
            state_ff <= tw_pkg::s_mstart;
            sda_oe <= 1'b1;
            rs_ff <= 1'b0;
          end
        end
        tw_pkg::s_mstart: begin
          cnt_ff <= half_done ? 16'h0000 : cnt_ff + 16'h0001;
          if (half_done && phase_ff == 2'h0) begin
            phase_ff <= 2'h1;
            scl_oe <= 1'b1;
          end else if (half_done) begin
            status_ff <= rs_ff ? `TW_CODE_RSTART : `TW_CODE_START;
            set_ff <= 1'b1;
            state_ff <= tw_pkg::s_wait;
          end
        end
        tw_pkg::s_mrestart: begin
          // Ownership is never given up here: no STOP between the two frames
          if (phase_ff == 2'h0) begin
            cnt_ff <= half_done ? 16'h0000 : cnt_ff + 16'h0001;
            if (qtr_pt) begin
              sda_oe <= 1'b0;
            end
            if (half_done) begin
              phase_ff <= 2'h1;
              scl_oe <= 1'b0;
            end
          end else if (!scl_s) begin
            cnt_ff <= 16'h0000;
          end else if (half_done) begin
            cnt_ff <= 16'h0000;
            phase_ff <= 2'h0;
            sda_oe <= 1'b1;
            rs_ff <= 1'b1;
            state_ff <= tw_pkg::s_mstart;
          end else begin
            cnt_ff <= cnt_ff + 16'h0001;
          end
        end
        tw_pkg::s_mstop: begin
          if (phase_ff == 2'h0) begin
            cnt_ff <= half_done ? 16'h0000 : cnt_ff + 16'h0001;
            if (qtr_pt) begin
              sda_oe <= 1'b1;
            end
            if (half_done) begin
              phase_ff <= 2'h1;
              scl_oe <= 1'b0;
            end
          end else if (phase_ff == 2'h1) begin
            if (!scl_s) begin
              cnt_ff <= 16'h0000;
            end else if (half_done) begin
              cnt_ff <= 16'h0000;
              phase_ff <= 2'h2;
              sda_oe <= 1'b0;
            end else begin
              cnt_ff <= cnt_ff + 16'h0001;
            end
          end else begin
            cnt_ff <= half_done ? 16'h0000 : cnt_ff + 16'h0001;
            if (half_done) begin
              stop_done_ff <= 1'b1;
              state_ff <= tw_pkg::s_idle;
            end
          end
        end
        tw_pkg::s_mbyte: begin
          if (phase_ff == 2'h0) begin
            cnt_ff <= half_done ? 16'h0000 : cnt_ff + 16'h0001;
            if (qtr_pt) begin
              sda_oe <= bit_drv;
            end
            if (half_done) begin
              phase_ff <= 2'h1;
              scl_oe <= 1'b0;
            end
          end else if (!scl_s) begin
            cnt_ff <= 16'h0000;
          end else if (!half_done) begin
            cnt_ff <= cnt_ff + 16'h0001;
          end else if (bit_ff < 4'd8) begin
            cnt_ff <= 16'h0000;
            sh_ff <= {sh_ff[6:0], sda_s};
            bit_ff <= bit_ff + 4'd1;
            if (tx_ff && sh_ff[7] && !sda_s) begin
              // Lost arbitration: follow the winner as a passive receiver
              state_ff <= tw_pkg::s_sbits;
              lost_ff <= 1'b1;
              sda_oe <= 1'b0;
            end else begin
              phase_ff <= 2'h0;
              scl_oe <= 1'b1;
            end
          end else begin
            cnt_ff <= 16'h0000;
            phase_ff <= 2'h0;
            scl_oe <= 1'b1;
            set_ff <= 1'b1;
            state_ff <= tw_pkg::s_wait;
            if (addr_ph_ff && dir_ff) begin
              status_ff <= ackd ? `TW_CODE_AR_ACK : `TW_CODE_AR_NACK;
            end else if (addr_ph_ff) begin
              status_ff <= ackd ? `TW_CODE_AW_ACK : `TW_CODE_AW_NACK;
            end else if (tx_ff) begin
              status_ff <= ackd ? `TW_CODE_DTX_ACK : `TW_CODE_DTX_NACK;
            end else begin
              status_ff <= ack_out_ff ? `TW_CODE_DRX_ACK : `TW_CODE_DRX_NACK;
              load_ff <= 1'b1;
            end
          end
        end
        tw_pkg::s_wait: begin
          scl_oe <= 1'b1;
          cnt_ff <= 16'h0000;
          phase_ff <= 2'h0;
          bit_ff <= 4'h0;
          if (!flag_ff && !set_ff) begin
            case (status_ff)
              `TW_CODE_START, `TW_CODE_RSTART: begin
                sh_ff <= data_ff;
                dir_ff <= data_ff[0];
                tx_ff <= 1'b1;
                addr_ph_ff <= 1'b1;
                state_ff <= tw_pkg::s_mbyte;
              end
              `TW_CODE_AW_ACK, `TW_CODE_AW_NACK, `TW_CODE_DTX_ACK, `TW_CODE_DTX_NACK,
              `TW_CODE_AR_NACK, `TW_CODE_DRX_NACK: begin
                if (sto_ff) begin
                  state_ff <= tw_pkg::s_mstop;
                end else if (sta_ff) begin
                  state_ff <= tw_pkg::s_mrestart;
                end else if (status_ff[7:4] == 4'h4 || status_ff[7:4] == 4'h5) begin
                  state_ff <= tw_pkg::s_mstop;
                end else begin
                  sh_ff <= data_ff;
                  tx_ff <= 1'b1;
                  addr_ph_ff <= 1'b0;
                  state_ff <= tw_pkg::s_mbyte;
                end
              end
              `TW_CODE_AR_ACK, `TW_CODE_DRX_ACK: begin
                tx_ff <= 1'b0;
                addr_ph_ff <= 1'b0;
                ack_out_ff <= ack_en_ff;
                state_ff <= tw_pkg::s_mbyte;
              end
              `TW_CODE_OWN_W, `TW_CODE_OWN_W_LOST, `TW_CODE_GC_W, `TW_CODE_GC_W_LOST,
              `TW_CODE_OWN_D_ACK, `TW_CODE_GC_D_ACK: begin
                scl_oe <= 1'b0;
                addr_ph_ff <= 1'b0;
                lost_ff <= 1'b0;
                state_ff <= tw_pkg::s_sbits;
              end
              default: begin
                // Lost arbitration and finished slave frames release the bus
                scl_oe <= 1'b0;
                sda_oe <= 1'b0;
                state_ff <= tw_pkg::s_idle;
              end
            endcase
          end
        end
        tw_pkg::s_sbits: begin
          scl_oe <= 1'b0;
          if (stop_det) begin
            state_ff <= tw_pkg::s_idle;
          end else if (start_det) begin
            bit_ff <= 4'h0;
            addr_ph_ff <= 1'b1;
          end else if (scl_rise && bit_ff < 4'd8) begin
            sh_ff <= {sh_ff[6:0], sda_s};
            bit_ff <= bit_ff + 4'd1;
          end else if (scl_fall && bit_ff == 4'd8) begin
            if (addr_ph_ff && addr_hit) begin
              sda_oe <= 1'b1;
              gc_ff <= gc_hit;
              state_ff <= tw_pkg::s_sack;
              if (sh_ff[0]) begin
                status_ff <= `TW_CODE_OWN_R;
              end else if (gc_hit) begin
                status_ff <= lost_ff ? `TW_CODE_GC_W_LOST : `TW_CODE_GC_W;
              end else begin
                status_ff <= lost_ff ? `TW_CODE_OWN_W_LOST : `TW_CODE_OWN_W;
              end
            end else if (lost_ff) begin
              status_ff <= `TW_CODE_ARB_LOST;
              set_ff <= 1'b1;
              scl_oe <= 1'b1;
              state_ff <= tw_pkg::s_wait;
            end else if (addr_ph_ff) begin
              state_ff <= tw_pkg::s_idle;
            end else begin
              // Byte after ack_enable dropped is answered with a released line
              sda_oe <= ack_en_ff;
              load_ff <= 1'b1;
              state_ff <= tw_pkg::s_sack;
              if (gc_ff) begin
                status_ff <= ack_en_ff ? `TW_CODE_GC_D_ACK : `TW_CODE_GC_D_NACK;
              end else begin
                status_ff <= ack_en_ff ? `TW_CODE_OWN_D_ACK : `TW_CODE_OWN_D_NACK;
              end
            end
          end
        end
        tw_pkg::s_sack: begin
          if (scl_fall) begin
            sda_oe <= 1'b0;
            scl_oe <= 1'b1;
            set_ff <= 1'b1;
            state_ff <= tw_pkg::s_wait;
          end
        end
        default: begin
          state_ff <= tw_pkg::s_idle;
        end
      endcase
    end
  end

  // Open-drain pads: only the enables move
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scl_o <= 1'b0;
      sda_o <= 1'b0;
    end else begin
      scl_o <= 1'b0;
      sda_o <= 1'b0;
    end
  end

  // ==========================================================================
  // Wake request: held until the power manager leaves deep sleep
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wake_req <= 1'b0;
    end else if (!deep_sleep) begin
      wake_req <= 1'b0;
    end else if (state_ff == tw_pkg::s_sbits && scl_fall && bit_ff == 4'd8 &&
                 addr_ph_ff && addr_hit) begin
      wake_req <= 1'b1;
    end
  end

  // ==========================================================================
  // APB slave: one wait state, writes land on the completing edge
  assign apb_acc = psel & penable;
  assign wr_go = apb_acc & pwrite & pready;
  assign rd_go = apb_acc & ~pwrite & ~pready;
  assign reg_hit = (paddr == AW'(`TW_OFF_CTRL)) || (paddr == AW'(`TW_OFF_STAT)) ||
                   (paddr == AW'(`TW_OFF_DATA)) || (paddr == AW'(`TW_OFF_ADDR));

  always_comb begin
    rd_byte = 8'h00;
    if (paddr == AW'(`TW_OFF_CTRL)) begin
      rd_byte = {flag_ff, ack_en_ff, sta_ff, sto_ff, wcol_ff, en_ff, 1'b0, ie_ff};
    end else if (paddr == AW'(`TW_OFF_STAT)) begin
      rd_byte = {status_ff[7:3], 3'b000};
    end else if (paddr == AW'(`TW_OFF_DATA)) begin
      rd_byte = data_ff;
    end else if (paddr == AW'(`TW_OFF_ADDR)) begin
      rd_byte = own_ff;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else begin
      pready <= apb_acc & ~pready;
      pslverr <= apb_acc & ~pready & ~reg_hit;
      if (rd_go) begin
        prdata <= {24'h000000, rd_byte};
      end
    end
  end

  // ==========================================================================
  // Control register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_ff <= 1'b0;
      ack_en_ff <= 1'b0;
      sta_ff <= 1'b0;
      sto_ff <= 1'b0;
      en_ff <= 1'b0;
      ie_ff <= 1'b0;
    end else begin
      // Hardware set wins over a clear written in the same cycle
      if (set_ff) begin
        flag_ff <= 1'b1;
      end else if (wr_go && paddr == AW'(`TW_OFF_CTRL) && pwdata[`TW_B_FLAG]) begin
        flag_ff <= 1'b0;
      end
      if (wr_go && paddr == AW'(`TW_OFF_CTRL)) begin
        ack_en_ff <= pwdata[`TW_B_ACK];
        sta_ff <= pwdata[`TW_B_STA];
        en_ff <= pwdata[`TW_B_EN];
        ie_ff <= pwdata[`TW_B_IE];
      end
      if (wr_go && paddr == AW'(`TW_OFF_CTRL)) begin
        sto_ff <= pwdata[`TW_B_STO];
      end else if (stop_done_ff) begin
        sto_ff <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // Data, collision and own address registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      data_ff <= `TW_RST_BYTE;
      wcol_ff <= 1'b0;
    end else begin
      if (load_ff && !deep_sleep) begin
        data_ff <= sh_ff;
      end else if (wr_go && paddr == AW'(`TW_OFF_DATA) && flag_ff) begin
        data_ff <= pwdata[7:0];
      end
      if (wr_go && paddr == AW'(`TW_OFF_DATA)) begin
        wcol_ff <= ~flag_ff;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      own_ff <= `TW_RST_BYTE;
    end else if (wr_go && paddr == AW'(`TW_OFF_ADDR)) begin
      own_ff <= pwdata[7:0];
    end
  end

endmodule // tw_core

`default_nettype wire

/* File: tw_core_chk.sv */
/* Checker for tw_core: APB timing, read shapes, SCL hold while flagged, wake.
   Assumes it is bound to tw_core and sees only its ports. */
`timescale 1ns/1ps
`default_nettype none
`include "tw_defs.svh"
module tw_core_chk #(
  parameter int AW = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [AW-1:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic scl_oe,
  input wire logic deep_sleep,
  input wire logic wake_req
);
  // ==========================================================================
  // Properties
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic rdv;
  assign rdv = pready && !pwrite;
  a_ready_pulse: assert property (pready |=> !pready) else $error("pready too long");
  a_ready_wait: assert property (psel && $rose(penable) |=> pready)
    else $error("pready not in second access cycle");
  a_err_map: assert property (pready && paddr <= 8'h0c && paddr[1:0] == 2'h0 |-> !pslverr)
    else $error("pslverr on mapped address");
  a_err_zero: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
    else $error("unmapped read not zero");
  a_flag_hold: assert property (rdv && paddr == `TW_OFF_CTRL && prdata[7] |-> scl_oe)
    else $error("scl released with flag set");
  a_stat_shape: assert property (rdv && paddr == `TW_OFF_STAT |-> prdata[2:0] == 3'h0)
    else $error("status low bits not zero");
  a_ctrl_shape: assert property (rdv && paddr == `TW_OFF_CTRL |-> prdata[31:8] == 24'h0)
    else $error("control upper bits not zero");
  a_wake_drop: assert property (!deep_sleep |=> !wake_req)
    else $error("wake request while awake");
  cover property (rdv && paddr == `TW_OFF_STAT && prdata[7:0] == 8'h58);
  cover property (rdv && paddr == `TW_OFF_STAT && prdata[7:0] == 8'h48);
  cover property (pready && pslverr);
endmodule // tw_core_chk
bind tw_core tw_core_chk #(.AW(AW)) i_chk (
  .pclk(pclk),
  .presetn(presetn),
  .psel(psel),
  .penable(penable),
  .pwrite(pwrite),
  .paddr(paddr),
  .prdata(prdata),
  .pready(pready),
  .pslverr(pslverr),
  .scl_oe(scl_oe),
  .deep_sleep(deep_sleep),
  .wake_req(wake_req)
);
`default_nettype wire

/* File: tw_peer.sv */
/* Far-side slave transmitter: answers its address, sends TXB, TXB+1, ...
   Assumes pulled-up scl/sda wires; it only pulls sda low, never stretches. */
`timescale 1ns/1ps
`default_nettype none
module tw_peer #(
  parameter logic [6:0] ADDR = 7'h2a,
  parameter logic [7:0] TXB = 8'ha5
) (
  input wire logic scl,
  input wire logic sda,
  output logic sda_oe
);
  logic [7:0] sh;
  logic [7:0] tx = TXB;
  logic act = 0;
  logic ap = 0;
  logic rd = 0;
  int n = 0;
  initial sda_oe = 0;
  always @(negedge sda) if (scl) begin
    act = 1;
    ap = 1;
    rd = 0;
    n = 0;
    sda_oe = 0;
  end
  always @(posedge sda) if (scl) act = 0;
  always @(posedge scl) if (act) begin
    if (n < 8) sh = {sh[6:0], sda};
    else if (n == 8 && rd && !ap) begin
      if (sda) act = 0;
      else tx = tx + 8'h01;
    end
    n = n + 1;
  end
  always @(negedge scl) if (act) begin
    if (n == 8 && ap) begin
      if (sh[7:1] == ADDR) begin
        sda_oe = 1;
        rd = sh[0];
      end else act = 0;
    end else if (n == 9) begin
      ap = 0;
      n = 0;
      sda_oe = rd & ~tx[7];
    end else if (rd && !ap) sda_oe = (n < 8) ? ~tx[7-n] : 1'b0;
  end
endmodule // tw_peer
`default_nettype wire

/* File: test_two_wire_master_rx_slave_rx.sv */
/* Bench for tw_core: registers over APB, master read against tw_peer.
   Assumes the design's one-wait-state APB and a short SCL half period. */
`timescale 1ns/1ps
`default_nettype none
`include "tw_defs.svh"
module test_two_wire_master_rx_slave_rx;
  logic pclk = 0;
  logic presetn = 0;
  logic psel = 0;
  logic penable = 0;
  logic pwrite = 0;
  logic deep_sleep = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic [31:0] q;
  logic pready, pslverr, perr, scl_oe, sda_oe, wake_req, m_oe, b_scl = 0, b_sda = 0;
  wire scl = ~(scl_oe | b_scl);
  wire sda = ~(sda_oe | m_oe | b_sda);
  int err_count = 0;
  int checks = 0;
  always #4 pclk = ~pclk;
  tw_core #(.HALF_CYC(10)) i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .scl_i(scl), .scl_o(), .scl_oe(scl_oe),
    .sda_i(sda), .sda_o(), .sda_oe(sda_oe), .deep_sleep(deep_sleep), .wake_req(wake_req));
  tw_peer i_peer (.scl(scl), .sda(sda), .sda_oe(m_oe));
  // ==========================================================================
  // Tasks
  task automatic final_report();
    $display("checks=%0d err_count=%0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    for (int i = 0; i < 20; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) begin
        q = prdata;
        perr = pslverr;
        psel <= 0;
        penable <= 0;
        @(posedge pclk);
        return;
      end
    end
    err_count++;
    final_report();
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m, input string nm);
    apb(0, a, 32'h0);
    cmp(nm, e, q & m);
  endtask
  task automatic wait_ctl(input int b, input logic v);
    for (int i = 0; i < 300; i++) begin
      apb(0, `TW_OFF_CTRL, 32'h0);
      if (q[b] === v) return;
    end
    err_count++;
    final_report();
  endtask
  task automatic bb(input logic [8:0] v);
    for (int i = 8; i >= 0; i--) begin
      b_scl <= 1;
      repeat (5) @(posedge pclk);
      b_sda <= ~v[i];
      repeat (5) @(posedge pclk);
      b_scl <= 0;
      repeat (10) @(posedge pclk);
    end
    b_scl <= 1;
  endtask
  task automatic step(input logic [7:0] c, input logic [7:0] st, input string nm);
    apb(1, `TW_OFF_CTRL, {24'h0, c});
    wait_ctl(7, 1);
    rd(`TW_OFF_STAT, {24'h0, st}, 32'hf8, nm);
  endtask
  // ==========================================================================
  // Sequence
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1;
    repeat (3) @(posedge pclk);
    rd(`TW_OFF_CTRL, 32'h0, '1, "ctrl reset");
    rd(`TW_OFF_STAT, {24'h0, `TW_RST_CODE}, '1, "status reset");
    rd(`TW_OFF_DATA, 32'h0, '1, "data reset");
    rd(`TW_OFF_ADDR, 32'h0, '1, "own address reset");
    rd(8'h10, 32'h0, '1, "unmapped read");
    cmp("unmapped pslverr", 32'h1, {31'h0, perr});
    apb(1, `TW_OFF_DATA, 32'h11);
    rd(`TW_OFF_CTRL, 32'h08, '1, "write collision");
    apb(1, `TW_OFF_ADDR, 32'h66);
    rd(`TW_OFF_ADDR, 32'h66, '1, "own address");
    deep_sleep <= 1;
    @(posedge pclk);
    deep_sleep <= 0;
    repeat (2) @(posedge pclk);
    cmp("wake idle", 32'h0, {31'h0, wake_req});
    step(8'ha4, 8'h08, "start status");
    cmp("scl held", 32'h1, {31'h0, scl_oe});
    apb(1, `TW_OFF_DATA, 32'h55);
    step(8'hc4, 8'h40, "read address ack");
    step(8'hc4, 8'h50, "byte acked");
    rd(`TW_OFF_DATA, 32'ha5, '1, "first byte");
    step(8'h84, 8'h58, "byte not acked");
    rd(`TW_OFF_DATA, 32'ha6, '1, "last byte");
    step(8'ha4, 8'h10, "repeated start");
    apb(1, `TW_OFF_DATA, 32'hef);
    step(8'h84, 8'h48, "address not acked");
    apb(1, `TW_OFF_CTRL, 32'h94);
    wait_ctl(4, 0);
    rd(`TW_OFF_CTRL, 32'h0, 32'h90, "stop done");
    apb(1, `TW_OFF_CTRL, 32'h44);
    deep_sleep <= 1;
    b_sda <= 1;
    repeat (10) @(posedge pclk);
    bb(9'h0cd);
    wait_ctl(7, 1);
    rd(`TW_OFF_STAT, 32'h60, 32'hf8, "own address write");
    cmp("wake on match", 32'h1, {31'h0, wake_req});
    deep_sleep <= 0;
    apb(1, `TW_OFF_CTRL, 32'h84);
    bb(9'h079);
    wait_ctl(7, 1);
    rd(`TW_OFF_STAT, 32'h88, 32'hf8, "slave nack");
    rd(`TW_OFF_DATA, 32'h3c, '1, "slave byte");
    final_report();
  end
endmodule // test_two_wire_master_rx_slave_rx
`default_nettype wire
